// ### design/timer_mode_pkg.sv
// package: register map, field layout, reset values and write masks of the timer mode block
package timer_mode_pkg;
	localparam logic [15:0] TMC_OFFSET = 16'hffba;
	localparam logic [15:0] CRC_OFFSET = 16'hffbc;
	localparam logic [15:0] PRM_OFFSET = 16'hffbb;
	localparam logic [15:0] CMP0_OFFSET = 16'hff12;
	localparam logic [15:0] CMP1_OFFSET = 16'hff14;
	localparam logic [15:0] COUNT_OFFSET = 16'hff10;
	localparam logic [15:0] IRQ_STAT_OFFSET = 16'hff40;
	localparam logic [15:0] IRQ_MASK_OFFSET = 16'hff44;
	localparam logic [15:0] BITOP_OFFSET = 16'hff48;
	localparam int OVF_POS = 0;
	localparam int TOGGLE_SEL_POS = 1;
	localparam int RUN_LO_POS = 2;
	localparam int RUN_HI_POS = 3;
	localparam int ES_LO_POS = 4;
	localparam int ES_HI_POS = 5;
	localparam logic [7:0] TMC_RESET = 8'h00;
	localparam logic [7:0] CRC_RESET = 8'h00;
	localparam logic [7:0] PRM_RESET = 8'h00;
	localparam logic [7:0] TMC_WMASK = 8'h0f;
	localparam logic [7:0] CRC_WMASK = 8'h07;
	localparam logic [15:0] CMP_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	localparam int IRQ_OVF = 0;
	localparam int IRQ_CMP0 = 1;
	localparam int IRQ_CMP1 = 2;
	localparam int IRQ_EDGE = 3;

	typedef enum logic [1:0] {
		MODE_STOP,
		MODE_FREE,
		MODE_EDGE_CLEAR,
		MODE_MATCH_CLEAR
	} run_mode_e;

	typedef enum logic [1:0] {
		EDGE_FALL,
		EDGE_RISE,
		EDGE_RSVD,
		EDGE_BOTH
	} edge_sel_e;

	typedef struct packed {
		logic [15:0] addr;
		logic write;
		logic [31:0] wdata;
		logic [3:0] strb;
	} bus_req_s;

	typedef struct packed {
		logic run_hi;
		logic run_lo;
		logic toggle_sel;
		logic ovf;
	} tmc_fields_s;
endpackage : timer_mode_pkg

// ### design/pin_sync.sv
// two-stage synchroniser followed by an edge detector for one pin
`timescale 1ns/100ps
module pin_sync
	import timer_mode_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pin,
	input wire logic [1:0] edge_sel,
	output logic level,
	output logic valid_edge
);
	logic meta;
	logic prev;
	wire rise = level & ~prev;
	wire fall = ~level & prev;
	edge_sel_e sel;

	assign sel = edge_sel_e'(edge_sel);
	// first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 1'b0;
			level <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= pin;
			level <= meta;
			prev <= level;
		end
	end

	always_comb begin
		unique case (sel)
			EDGE_FALL: valid_edge = fall;
			EDGE_RISE: valid_edge = rise;
			EDGE_RSVD: valid_edge = 1'b0;
			EDGE_BOTH: valid_edge = rise | fall;
		endcase
	end
endmodule : pin_sync

// ### design/count_core.sv
// 16-bit up counter with stop-reset, clear request and read-hold
`timescale 1ns/100ps
module count_core
	import timer_mode_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic clear,
	input wire logic hold,
	output logic [15:0] count,
	output logic wrap
);
	logic pend;
	// the parked tick is added with the next one so no pulse is lost
	wire [15:0] inc = count + 16'h0001 + {15'h0000, pend};
	wire at_max = count == COUNT_MAX;
	wire near_max = pend & (count == (COUNT_MAX - 16'h0001));

	// a tick seen during a read is parked and applied afterwards
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= CMP_RESET;
			pend <= 1'b0;
		end else if (!run) begin
			count <= CMP_RESET;
			pend <= 1'b0;
		end else if (clear) begin
			count <= CMP_RESET;
			pend <= 1'b0;
		end else if (hold) begin
			pend <= 1'b1;
		end else begin
			count <= inc;
			pend <= 1'b0;
		end
	end

	assign wrap = run & ~hold & ~clear & (at_max | near_max);
endmodule : count_core

// ### design/timer_mode_control.sv
// mode control, compare, output toggle and apb registers of the 16-bit timer
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - mode register is 8 bits, reset zero
// - mode register takes bit and byte writes
// - nonzero run field starts counting; zero stops
// - run field zero stops and resets counter
// - modes: free, edge clear, compare clear
// - wrap from maximum to zero sets overflow
// - writing one sets overflow flag
// - writing zero or stopping clears overflow
// - trigger edge polarity from prescaler bits 5:4
// - capture control resets zero, bit or byte writes
// - count read pauses clock, loses no pulse
module timer_mode_control
	import timer_mode_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic trigger_input_pin,
	output logic timer_output_pin,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] timer_mode_control_reg;
	logic [7:0] capture_compare_control_reg;
	logic [7:0] prescaler_mode_register;
	logic [15:0] first_compare_register;
	logic [15:0] second_compare_register;
	logic [3:0] irq_status;
	logic [3:0] irq_mask;
	logic [15:0] count_value;
	logic wrap;
	logic trig_level;
	logic trig_edge;
	logic [31:0] next_rdata;
	bus_req_s req;
	tmc_fields_s tmc;
	run_mode_e mode;

	assign req = '{addr: paddr, write: pwrite, wdata: pwdata, strb: pstrb};
	assign tmc = tmc_fields_s'(timer_mode_control_reg[3:0]);
	assign mode = run_mode_e'({tmc.run_hi, tmc.run_lo});

	////////////////////////////////////////////////////////////////////////
	// apb decode; every access completes in its first access cycle
	wire access = psel & penable;
	wire wr = access & req.write;
	wire rd = access & ~req.write;
	wire lane0 = req.strb[0];
	wire lane1 = req.strb[1];
	wire sel_tmc = req.addr == TMC_OFFSET;
	wire sel_crc = req.addr == CRC_OFFSET;
	wire sel_prm = req.addr == PRM_OFFSET;
	wire sel_cmp0 = req.addr == CMP0_OFFSET;
	wire sel_cmp1 = req.addr == CMP1_OFFSET;
	wire sel_count = req.addr == COUNT_OFFSET;
	wire sel_stat = req.addr == IRQ_STAT_OFFSET;
	wire sel_mask = req.addr == IRQ_MASK_OFFSET;
	wire sel_bitop = req.addr == BITOP_OFFSET;
	wire mapped = sel_tmc | sel_crc | sel_prm | sel_cmp0 | sel_cmp1
		| sel_count | sel_stat | sel_mask | sel_bitop;
	wire wr_tmc = wr & sel_tmc & lane0;
	wire wr_crc = wr & sel_crc & lane0;
	wire wr_prm = wr & sel_prm & lane0;
	wire wr_stat = wr & sel_stat & lane0;
	wire wr_mask = wr & sel_mask & lane0;
	// single-bit op: wdata[2:0] bit index, wdata[3] value, wdata[4] target
	wire wr_bitop = wr & sel_bitop & lane0;
	wire [7:0] bit_onehot = 8'h01 << req.wdata[2:0];
	wire bitop_crc = req.wdata[4];
	wire bitop_tmc = wr_bitop & ~bitop_crc;
	wire bitop_crcw = wr_bitop & bitop_crc;
	wire [7:0] tmc_set = req.wdata[3] ? bit_onehot : 8'h00;

	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	////////////////////////////////////////////////////////////////////////
	// mode register byte and bit writes
	wire [7:0] tmc_byte = req.wdata[7:0] & TMC_WMASK;
	wire [7:0] tmc_bit = ((timer_mode_control_reg & ~bit_onehot) | tmc_set)
		& TMC_WMASK;
	wire tmc_we = wr_tmc | bitop_tmc;
	wire [7:0] tmc_wval = wr_tmc ? tmc_byte : tmc_bit;
	wire running = mode != MODE_STOP;
	wire [1:0] next_mode = tmc_we ? tmc_wval[RUN_HI_POS:RUN_LO_POS]
		: {tmc.run_hi, tmc.run_lo};
	wire flag_sw_set = tmc_we & tmc_wval[OVF_POS];
	wire flag_sw_clr = tmc_we & ~tmc_wval[OVF_POS];
	wire flag_stop = next_mode == 2'b00;
	// hardware set wins over a software clear in the same cycle
	wire next_ovf = flag_sw_set | (wrap & running)
		| (tmc.ovf & ~flag_sw_clr & ~flag_stop);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_mode_control_reg <= TMC_RESET;
		end else begin
			if (tmc_we) begin
				timer_mode_control_reg[3:1] <= tmc_wval[3:1];
			end
			timer_mode_control_reg[OVF_POS] <= next_ovf & ~flag_stop;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// capture control, prescaler edge select and compare registers
	wire [7:0] crc_bit = ((capture_compare_control_reg & ~bit_onehot)
		| tmc_set) & CRC_WMASK;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_compare_control_reg <= CRC_RESET;
			prescaler_mode_register <= PRM_RESET;
		end else begin
			if (wr_crc) begin
				capture_compare_control_reg <= req.wdata[7:0] & CRC_WMASK;
			end else if (bitop_crcw) begin
				capture_compare_control_reg <= crc_bit;
			end
			if (wr_prm) begin
				prescaler_mode_register <= req.wdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_compare_register <= CMP_RESET;
			second_compare_register <= CMP_RESET;
		end else begin
			if (wr & sel_cmp0 & lane0) begin
				first_compare_register[7:0] <= req.wdata[7:0];
			end
			if (wr & sel_cmp0 & lane1) begin
				first_compare_register[15:8] <= req.wdata[15:8];
			end
			if (wr & sel_cmp1 & lane0) begin
				second_compare_register[7:0] <= req.wdata[7:0];
			end
			if (wr & sel_cmp1 & lane1) begin
				second_compare_register[15:8] <= req.wdata[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trigger pin, counter and mode actions
	pin_sync u_trig (
		.pclk(pclk),
		.presetn(presetn),
		.pin(trigger_input_pin),
		.edge_sel(prescaler_mode_register[ES_HI_POS:ES_LO_POS]),
		.level(trig_level),
		.valid_edge(trig_edge)
	);

	wire edge_run = trig_edge & running;
	wire match0 = running & (count_value == first_compare_register);
	wire match1 = running & (count_value == second_compare_register);
	// a count read freezes the counter for its access cycle
	wire count_read = rd & sel_count;
	logic clear_req;

	always_comb begin
		unique case (mode)
			MODE_STOP: clear_req = 1'b0;
			MODE_FREE: clear_req = 1'b0;
			MODE_EDGE_CLEAR: clear_req = edge_run;
			MODE_MATCH_CLEAR: clear_req = match0;
		endcase
	end

	count_core u_core (
		.pclk(pclk),
		.presetn(presetn),
		.run(running),
		.clear(clear_req),
		.hold(count_read),
		.count(count_value),
		.wrap(wrap)
	);

	wire toggle = match0 | match1 | (tmc.toggle_sel & edge_run);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_output_pin <= 1'b0;
		end else if (toggle) begin
			timer_output_pin <= ~timer_output_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky interrupt status, write one to clear; set beats clear
	wire [3:0] irq_events = {edge_run, match1, match0, wrap & running};
	wire [3:0] irq_clr = wr_stat ? req.wdata[3:0] : 4'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= IRQ_RESET;
			irq_mask <= IRQ_RESET;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_events;
			if (wr_mask) begin
				irq_mask <= req.wdata[3:0];
			end
		end
	end

	assign irq = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////
	// read mux; upper mode bits are never stored so read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (sel_tmc) next_rdata[7:0] = timer_mode_control_reg;
		if (sel_crc) next_rdata[7:0] = capture_compare_control_reg;
		if (sel_prm) next_rdata[7:0] = prescaler_mode_register;
		if (sel_cmp0) next_rdata[15:0] = first_compare_register;
		if (sel_cmp1) next_rdata[15:0] = second_compare_register;
		if (sel_count) next_rdata[15:0] = count_value;
		if (sel_stat) next_rdata[3:0] = irq_status;
		if (sel_mask) next_rdata[3:0] = irq_mask;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_stop_clears_count: assert property (@(posedge pclk) disable iff (!presetn)
		!running |=> count_value == 16'h0000)
		else $error("count not zero while stopped");
	a_ovf_on_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(running && wrap && !(tmc_we && next_mode == 2'b00)) |=> tmc.ovf)
		else $error("overflow flag not set on wrap");
	a_ovf_sw_set: assert property (@(posedge pclk) disable iff (!presetn)
		(flag_sw_set && !flag_stop) |=> tmc.ovf)
		else $error("overflow flag not set by write of one");
	a_ovf_stop_clear: assert property (@(posedge pclk) disable iff (!presetn)
		!running |-> !tmc.ovf)
		else $error("overflow flag set while stopped");
	a_upper_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
		timer_mode_control_reg[7:4] == 4'h0)
		else $error("upper mode bits not zero");
	a_count_steps: assert property (@(posedge pclk) disable iff (!presetn)
		(running && !clear_req && !count_read && !$past(count_read)
		&& $past(running)) |=> count_value == $past(count_value) + 16'h0001
		|| !running)
		else $error("count did not increment");
	a_read_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(count_read && running && !clear_req) |=>
		count_value == $past(count_value) ##1
		(!running || count_value == $past(count_value, 2) + 16'h0002
		|| $past(count_read) || $past(clear_req)))
		else $error("count read lost or moved a count");
	a_toggle_out: assert property (@(posedge pclk) disable iff (!presetn)
		toggle |=> timer_output_pin != $past(timer_output_pin))
		else $error("output did not toggle");
	a_match_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == MODE_MATCH_CLEAR && match0 && !tmc_we) |=>
		count_value == 16'h0000)
		else $error("compare match did not clear count");
	a_crc_byte_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_crc |=> capture_compare_control_reg ==
		($past(req.wdata[7:0]) & CRC_WMASK))
		else $error("capture control byte write lost");
endmodule : timer_mode_control

// ### bench/pin_model.sv
// pin-side partner: drives the trigger pin and counts timer output toggles
`timescale 1ns/100ps
module pin_model
	import timer_mode_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	output logic trigger_input_pin,
	input wire logic timer_output_pin
);
	int toggles = 0;
	logic last = 1'b0;
	initial trigger_input_pin = 1'b0;
	////////////////////////////////////////////////////////////////////////
	// every level change of the output counts once; reset time is ignored
	always @(posedge pclk) begin
		if (presetn === 1'b1 && timer_output_pin !== last) begin
			toggles <= toggles + 1;
		end
		last <= timer_output_pin;
	end
	////////////////////////////////////////////////////////////////////////
	// level changes just after a rising edge, held until the next call
	task drive(input logic v);
		@(posedge pclk);
		trigger_input_pin <= v;
	endtask : drive
endmodule : pin_model

// ### bench/tb.sv
// self-checking bench for the timer mode control block
`timescale 1ns/100ps
module tb
	import timer_mode_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic trigger_input_pin;
	logic timer_output_pin;
	logic irq;
	logic [31:0] rv;
	logic [31:0] c1;
	logic ev;
	int n_errors = 0;
	int total_checks = 0;
	int t0;
	int i;
	always #5 pclk = ~pclk;
	timer_mode_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trigger_input_pin(trigger_input_pin),
		.timer_output_pin(timer_output_pin), .irq(irq));
	pin_model pins (.pclk(pclk), .presetn(presetn),
		.trigger_input_pin(trigger_input_pin),
		.timer_output_pin(timer_output_pin));
	////////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task chk_bit(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask : chk_bit
	// one transfer; starts a cycle after the previous release
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 16) begin
			n_errors++;
			stop_test();
		end
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input logic [15:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		rd(TMC_OFFSET);
		chk("tmc reset", 32'h0, rv);
		chk_bit("mapped err", 1'b0, ev);
		rd(CRC_OFFSET);
		chk("crc reset", 32'h0, rv);
		rd(COUNT_OFFSET);
		chk("count stopped", 32'h0, rv);
		rd(16'h0000);
		chk_bit("unmapped err", 1'b1, ev);
		chk("unmapped data", 32'h0, rv);
		chk_bit("irq reset", 1'b0, irq);
	endtask : t_reset
	task t_fields;
		wr(TMC_OFFSET, 32'hf0);
		rd(TMC_OFFSET);
		chk("tmc upper", 32'h0, rv);
		wr(BITOP_OFFSET, 32'h09);
		rd(TMC_OFFSET);
		chk("tmc bit set", 32'h02, rv);
		wr(BITOP_OFFSET, 32'h01);
		rd(TMC_OFFSET);
		chk("tmc bit clear", 32'h0, rv);
		wr(BITOP_OFFSET, 32'h1a);
		rd(CRC_OFFSET);
		chk("crc bit set", 32'h04, rv);
		wr(CRC_OFFSET, 32'hff);
		rd(CRC_OFFSET);
		chk("crc byte", 32'h07, rv);
		wr(CRC_OFFSET, 32'h0);
	endtask : t_fields
	task t_free;
		wr(TMC_OFFSET, 32'h04);
		rd(COUNT_OFFSET);
		c1 = rv;
		rd(COUNT_OFFSET);
		chk_bit("count runs", 1'b1, c1 != 32'h0);
		chk_bit("count step", 1'b1, rv - c1 >= 32'd1 && rv - c1 <= 32'd4);
		wr(TMC_OFFSET, 32'h0);
		rd(COUNT_OFFSET);
		chk("count cleared", 32'h0, rv);
	endtask : t_free
	task t_ovf;
		wr(IRQ_MASK_OFFSET, 32'h1);
		wr(TMC_OFFSET, 32'h04);
		for (i = 0; i < 70000; i++) begin
			@(posedge pclk);
			if (irq === 1'b1) break;
		end
		if (i == 70000) begin
			n_errors++;
			stop_test();
		end
		chk_bit("wrap period", 1'b1, i > 65000);
		rd(TMC_OFFSET);
		chk("ovf set", 32'h05, rv);
		rd(IRQ_STAT_OFFSET);
		chk_bit("stat ovf", 1'b1, rv[IRQ_OVF]);
		wr(IRQ_MASK_OFFSET, 32'h0);
		@(negedge pclk);
		chk_bit("irq masked", 1'b0, irq);
		wr(IRQ_MASK_OFFSET, 32'h1);
		@(negedge pclk);
		chk_bit("irq unmasked", 1'b1, irq);
		wr(IRQ_STAT_OFFSET, 32'h1);
		@(negedge pclk);
		chk_bit("irq cleared", 1'b0, irq);
		wr(TMC_OFFSET, 32'h04);
		rd(TMC_OFFSET);
		chk("ovf sw clear", 32'h04, rv);
		wr(TMC_OFFSET, 32'h05);
		rd(TMC_OFFSET);
		chk("ovf sw set", 32'h05, rv);
		wr(TMC_OFFSET, 32'h0);
		rd(TMC_OFFSET);
		chk("ovf stop clear", 32'h0, rv);
	endtask : t_ovf
	task t_match;
		wr(CMP0_OFFSET, 32'h10);
		wr(CMP1_OFFSET, 32'hfff0);
		t0 = pins.toggles;
		wr(TMC_OFFSET, 32'h0c);
		repeat (4) begin
			rd(COUNT_OFFSET);
			chk_bit("count bound", 1'b1, rv <= 32'h10);
		end
		repeat (40) @(posedge pclk);
		chk_bit("match toggles", 1'b1, pins.toggles - t0 >= 2);
		rd(IRQ_STAT_OFFSET);
		chk_bit("stat cmp0", 1'b1, rv[IRQ_CMP0]);
		wr(TMC_OFFSET, 32'h0);
	endtask : t_match
	// compares sit out of reach so only trigger edges act
	task t_edge;
		wr(CMP0_OFFSET, 32'hfff0);
		wr(CMP1_OFFSET, 32'hfff1);
		wr(PRM_OFFSET, 32'h10);
		wr(TMC_OFFSET, 32'h0a);
		repeat (40) @(posedge pclk);
		t0 = pins.toggles;
		pins.drive(1'b1);
		repeat (8) @(posedge pclk);
		rd(COUNT_OFFSET);
		chk_bit("rise clears", 1'b1, rv < 32'd12);
		chk("rise toggle", t0 + 1, pins.toggles);
		pins.drive(1'b0);
		repeat (8) @(posedge pclk);
		rd(COUNT_OFFSET);
		chk_bit("fall ignored", 1'b1, rv >= 32'd12);
		chk("fall no toggle", t0 + 1, pins.toggles);
		wr(TMC_OFFSET, 32'h0);
		wr(PRM_OFFSET, 32'h0);
		wr(TMC_OFFSET, 32'h08);
		repeat (40) @(posedge pclk);
		t0 = pins.toggles;
		pins.drive(1'b1);
		repeat (8) @(posedge pclk);
		pins.drive(1'b0);
		repeat (8) @(posedge pclk);
		rd(COUNT_OFFSET);
		chk_bit("fall clears", 1'b1, rv < 32'd12);
		chk("edge no toggle", t0, pins.toggles);
		wr(TMC_OFFSET, 32'h0);
	endtask : t_edge
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fields();
		t_free();
		t_ovf();
		t_match();
		t_edge();
		stop_test();
	end
endmodule : tb
